// ===== bench/tb_usb_hub_reset_sequencer.sv
// Purpose: Self-checking bench for both ends of the hub reset sequencer
// Assumes: Shortened timing parameters on both ends
// Notes: Host end runs the link; the bench drives both user sides
`timescale 1ns/1ps
module tb_usb_hub_reset_sequencer;
   localparam int RCV = 50;
   localparam int EEC = 200;
   localparam int RQC = 40;
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic hw_reset_i = 1'b0;
   logic [1:0] mode_i = 2'h0;
   logic cfg_load_done_i = 1'b0;
   logic req_i = 1'b0;
   logic [6:0] port_en_req_i = 7'h00;
   logic [6:0] port_pwr_req_i = 7'h00;
   logic set_addr_i = 1'b0;
   logic [6:0] addr_i = 7'h00;
   logic set_cfg_i = 1'b0;
   logic cfg_val_i = 1'b0;
   logic suspend_i = 1'b0;
   logic req_ack_i = 1'b0;
   logic [6:0] port_enable_o, port_power_enable_o, addr_o;
   logic phy_enable_o, osc_enable_o, pll_enable_o, led_enable_o, operational_o;
   logic [1:0] mode_o;
   logic configured_o, suspended_o, tt_clear_o, req_o, req_late_o;
   logic attached_o, ready_o, cfg_start_o, req_busy_o, req_done_o;
   int error_cnt = 0;
   int compares = 0;
   int late_cnt = 0;
   uhrs_if lnk ();
   // Clock generation
   always #5 ref_clk_i = ~ref_clk_i;
   // Count late answers
   always @(posedge ref_clk_i) if (req_late_o === 1'b1) late_cnt++;
   uhrs_dev #(.RECOVER_CYC(RCV), .EE_LOAD_CYC(EEC), .REQ_CYC(RQC)) uhrs_dev_i (
      .ref_clk_i, .rst_i, .link(lnk), .port_en_req_i, .port_pwr_req_i, .set_addr_i,
      .addr_i, .set_cfg_i, .cfg_val_i, .suspend_i, .req_ack_i, .port_enable_o,
      .port_power_enable_o, .phy_enable_o, .osc_enable_o, .pll_enable_o, .led_enable_o,
      .operational_o, .mode_o, .addr_o, .configured_o, .suspended_o, .tt_clear_o,
      .req_o, .req_late_o);
   uhrs_host #(.ATTACH_WAIT_CYC(60), .BUS_RST_CYC(20)) uhrs_host_i (
      .ref_clk_i, .rst_i, .link(lnk), .hw_reset_i, .mode_i, .cfg_load_done_i, .req_i,
      .attached_o, .ready_o, .cfg_start_o, .req_busy_o, .req_done_o);
   uhrs_link_properties #(.RECOVER_CYC(RCV), .EE_LOAD_CYC(EEC), .REQ_CYC(RQC))
      uhrs_link_properties_i (.ref_clk_i, .rst_i, .reset_n(lnk.reset_n),
      .usb_reset(lnk.usb_reset), .cfg_mode(lnk.cfg_mode), .cfg_start(lnk.cfg_start),
      .cfg_done(lnk.cfg_done), .attach(lnk.attach), .req(lnk.req), .req_done(lnk.req_done));
   // Status selector for bounded waits
   function automatic logic sel(input int k);
      case (k)
         0: sel = operational_o;
         1: sel = attached_o;
         2: sel = cfg_start_o;
         3: sel = ready_o;
         4: sel = req_o;
         5: sel = req_done_o;
         6: sel = req_late_o;
         default: sel = tt_clear_o;
      endcase
   endfunction
   // Compare and report
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Final verdict
   task automatic close_out();
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Bounded wait for a status high
   task automatic wait_for(input int k, input int lim, input string nm);
      int n;
      n = 0;
      while (sel(k) !== 1'b1 && n < lim)
      begin
         @(posedge ref_clk_i);
         #1;
         n++;
      end
      if (sel(k) !== 1'b1)
      begin
         error_cnt++;
         $display("[ERR] %s expected 1 seen %b", nm, sel(k));
         close_out();
      end
   endtask
   // Pin reset in a given mode, checks what reset forces
   task automatic hw_reset(input logic [1:0] m);
      @(posedge ref_clk_i);
      mode_i <= m;
      cfg_load_done_i <= 1'b0;
      hw_reset_i <= 1'b1;
      @(posedge ref_clk_i);
      hw_reset_i <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      #1;
      chk("outputs in reset", 32'h0, {port_enable_o, port_power_enable_o, phy_enable_o,
         osc_enable_o, pll_enable_o, led_enable_o, operational_o, attached_o});
      chk("address in reset", 32'h0, {configured_o, addr_o});
      wait_for(0, RCV + 200, "operational");
      chk("captured mode", m, mode_o);
   endtask
   // Pulse one bench input for a cycle
   task automatic req_pulse();
      @(posedge ref_clk_i);
      req_i <= 1'b1;
      @(posedge ref_clk_i);
      req_i <= 1'b0;
      #1;
   endtask
   initial
   begin
      repeat (2) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      #1;
      hw_reset(uhrs_pkg::MODE_STRAP);
      wait_for(1, 20, "strap attach");
      chk("clocks and phy on", 32'hF, {phy_enable_o, osc_enable_o, pll_enable_o,
         led_enable_o});
      @(posedge ref_clk_i);
      port_en_req_i <= 7'h7F;
      port_pwr_req_i <= 7'h7F;
      set_addr_i <= 1'b1;
      addr_i <= 7'h55;
      set_cfg_i <= 1'b1;
      cfg_val_i <= 1'b1;
      suspend_i <= 1'b1;
      @(posedge ref_clk_i);
      set_addr_i <= 1'b0;
      set_cfg_i <= 1'b0;
      suspend_i <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      #1;
      chk("configured", 32'h7FFFD5, {port_enable_o, port_power_enable_o, configured_o,
         suspended_o, addr_o});
      wait_for(7, 150, "tt clear");
      chk("after bus reset", 32'h7F0000, {port_enable_o, port_power_enable_o, configured_o,
         suspended_o, addr_o});
      wait_for(3, 100, "host ready");
      $display("test bring-up and bus reset done");
      req_pulse();
      wait_for(4, 10, "request seen");
      chk("host busy", 32'h1, req_busy_o);
      @(posedge ref_clk_i);
      req_ack_i <= 1'b1;
      @(posedge ref_clk_i);
      req_ack_i <= 1'b0;
      #1;
      wait_for(5, 10, "request done");
      repeat (8) @(posedge ref_clk_i);
      req_pulse();
      wait_for(6, RQC + 10, "late answer");
      wait_for(5, 10, "late done");
      chk("late answers", 32'h1, late_cnt);
      $display("test requests done");
      hw_reset(uhrs_pkg::MODE_EEPROM);
      wait_for(2, 10, "config read start");
      chk("attached during load", 32'h0, attached_o);
      @(posedge ref_clk_i);
      cfg_load_done_i <= 1'b1;
      #1;
      wait_for(1, 20, "load attach");
      hw_reset(uhrs_pkg::MODE_EEPROM);
      wait_for(1, EEC + 30, "timeout attach");
      $display("test config read done");
      hw_reset(uhrs_pkg::MODE_SMBUS);
      repeat (2 * EEC) @(posedge ref_clk_i);
      #1;
      chk("attached before code load", 32'h0, attached_o);
      @(posedge ref_clk_i);
      cfg_load_done_i <= 1'b1;
      #1;
      wait_for(1, 20, "code load attach");
      $display("test code load done");
      hw_reset(2'h3);
      wait_for(1, 20, "spare mode attach");
      $display("test spare mode done");
      close_out();
   end
endmodule

// ===== bench/uhrs_link_properties.sv
// Purpose: Link timing checks between the hub end and the host end
// Assumes: Timing parameters match the bench instances
// Notes: Sees only the interface wires, clock and reset
`timescale 1ns/1ps
module uhrs_link_properties #(
   parameter int RECOVER_CYC = 50,
   parameter int EE_LOAD_CYC = 200,
   parameter int REQ_CYC = 40
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Link wires
   input wire logic reset_n,
   input wire logic usb_reset,
   input wire logic [1:0] cfg_mode,
   input wire logic cfg_start,
   input wire logic cfg_done,
   input wire logic attach,
   input wire logic req,
   input wire logic req_done
);
   localparam int R_LO = RECOVER_CYC - 8;
   localparam int R_HI = RECOVER_CYC;
   localparam int E_HI = EE_LOAD_CYC;
   localparam int Q_HI = REQ_CYC;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   // Hub answers cleared by reset pin
   a_rst_clears_link: assert property (!reset_n |=> !attach && !cfg_start && !req_done)
      else $error("hub link outputs not cleared in reset");
   // Strap mode attach after recovery
   a_strap_attach_time: assert property ($rose(reset_n) && cfg_mode == uhrs_pkg::MODE_STRAP
      |-> ##[R_LO:R_HI] $rose(attach))
      else $error("strap attach outside recovery window");
   // Config read starts once operational
   a_ee_read_start: assert property ($rose(reset_n) && cfg_mode == uhrs_pkg::MODE_EEPROM
      |-> ##[R_LO:R_HI] $rose(cfg_start))
      else $error("config read not started after recovery");
   // Config read bounded in time
   a_ee_read_bound: assert property ($rose(cfg_start) |-> ##[1:E_HI] $fell(cfg_start))
      else $error("config read ran too long");
   // Load completion ends the read and attaches
   a_ee_done_attach: assert property ($rose(cfg_done) && cfg_start
      |-> ##[2:6] (attach && !cfg_start))
      else $error("no attach after config load");
   // Code load mode never attaches early
   a_smb_no_early: assert property ($rose(attach) && cfg_mode == uhrs_pkg::MODE_SMBUS
      |-> $past(cfg_done, 3))
      else $error("attach before code load done");
   // Code load completion attaches
   a_smb_attach: assert property ($rose(cfg_done) && cfg_mode == uhrs_pkg::MODE_SMBUS
      && reset_n |-> ##[2:6] attach)
      else $error("no attach after code load");
   // Every request answered in time
   a_req_answer: assert property ($rose(req) |-> ##[1:Q_HI] req_done)
      else $error("request not completed in time");
   // Completion held while request stands
   a_req_hold: assert property (req_done && req && reset_n |=> req_done)
      else $error("completion dropped while request high");
   // Bus reset keeps the hub attached
   a_busrst_attached: assert property (usb_reset && reset_n |-> attach)
      else $error("hub detached during bus reset");
endmodule

// ===== hdl/uhrs_dev.sv
// Purpose: Hub end: hardware reset, recovery, config load, attach, bus reset
// Assumes: Link inputs are asynchronous; user side runs on ref_clk_i
// Notes: Reset pin asserts the core at once and releases it synchronously
`timescale 1ns/1ps
module uhrs_dev #(
   parameter int N = uhrs_pkg::NUM_PORTS,
   parameter int RECOVER_CYC = uhrs_pkg::RECOVER_CYC,
   parameter int EE_LOAD_CYC = uhrs_pkg::EE_LOAD_CYC,
   parameter int REQ_CYC = uhrs_pkg::REQ_CYC
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Link to host and config source
   uhrs_if.dev link,
   // Downstream port requests from hub logic
   input wire logic [N-1:0] port_en_req_i,
   input wire logic [N-1:0] port_pwr_req_i,
   // Standard device requests
   input wire logic set_addr_i,
   input wire logic [uhrs_pkg::ADDR_W-1:0] addr_i,
   input wire logic set_cfg_i,
   input wire logic cfg_val_i,
   input wire logic suspend_i,
   input wire logic req_ack_i,
   // Downstream port controls
   output logic [N-1:0] port_enable_o,
   output logic [N-1:0] port_power_enable_o,
   // Analog and clock controls
   output logic phy_enable_o,
   output logic osc_enable_o,
   output logic pll_enable_o,
   output logic led_enable_o,
   // Sequencer status
   output logic operational_o,
   output logic [1:0] mode_o,
   output logic [uhrs_pkg::ADDR_W-1:0] addr_o,
   output logic configured_o,
   output logic suspended_o,
   output logic tt_clear_o,
   // Request status
   output logic req_o,
   output logic req_late_o
);
   localparam int TW = uhrs_pkg::TMR_W;
   // Cycles lost to sync and hand-off, taken off each deadline
   localparam int RCV_LAT = 4;
   localparam int EE_LAT = 1;
   localparam int REQ_LAT = 5;

   typedef struct packed {
      uhrs_pkg::uhrs_dev_state_type st;
      logic armed;
      logic [1:0] mode;
      logic [2:0] ubr_s;
      logic [1:0] done_s;
      logic [2:0] req_s;
      logic [3:0] mode_s;
      logic osc_en;
      logic pll_en;
      logic phy_en;
      logic led_en;
      logic oper;
      logic cfg_start;
      logic attach;
      logic [N-1:0] port_en;
      logic [N-1:0] port_pwr;
      logic [uhrs_pkg::ADDR_W-1:0] addr;
      logic configured;
      logic suspended;
      logic tt_clear;
      logic req_pend;
      logic req_done;
      logic req_late;
   } uhrs_dev_reg_type;

   uhrs_dev_reg_type s_r;
   uhrs_dev_reg_type s_nxt;
   logic [1:0] hw_sync_r;
   logic hw_rst_a;
   logic core_rst;
   logic seq_load;
   logic [TW-1:0] seq_val;
   logic seq_done;
   logic req_load;
   logic req_tmo;
   logic ubr;
   logic ubr_rise;

   // Pin reset asserts at once, release passes two flops
   assign hw_rst_a = rst_i | ~link.reset_n;
   always_ff @(posedge ref_clk_i or posedge hw_rst_a)
   begin
      if (hw_rst_a)
         hw_sync_r <= 2'h0;
      else
         hw_sync_r <= {hw_sync_r[0], 1'b1};
   end
   assign core_rst = ~hw_sync_r[1];

   // Recovery and config load timeouts
   uhrs_timer #(.W(TW)) u_seq_tmr (
      .ref_clk_i(ref_clk_i),
      .rst_i(core_rst),
      .load_i(seq_load),
      .value_i(seq_val),
      .done_o(seq_done)
   );

   // Request completion deadline
   uhrs_timer #(.W(TW)) u_req_tmr (
      .ref_clk_i(ref_clk_i),
      .rst_i(core_rst),
      .load_i(req_load),
      .value_i(TW'(REQ_CYC - REQ_LAT)),
      .done_o(req_tmo)
   );

   // Synchronized bus reset level and edge
   assign ubr = s_r.ubr_s[1];
   assign ubr_rise = s_r.ubr_s[1] & ~s_r.ubr_s[2];

   // Next state of the sequencer
   always_comb
   begin
      s_nxt = s_r;
      seq_load = 1'b0;
      seq_val = TW'(RECOVER_CYC - RCV_LAT);
      req_load = 1'b0;
      s_nxt.armed = 1'b1;
      s_nxt.tt_clear = 1'b0;
      s_nxt.req_late = 1'b0;
      s_nxt.ubr_s = {s_r.ubr_s[1:0], link.usb_reset};
      s_nxt.done_s = {s_r.done_s[0], link.cfg_done};
      s_nxt.req_s = {s_r.req_s[1:0], link.req};
      s_nxt.mode_s = {s_r.mode_s[1:0], link.cfg_mode};
      // Clocks run again once the core leaves reset
      s_nxt.osc_en = 1'b1;
      s_nxt.pll_en = 1'b1;
      // Recovery timer starts on the synchronized release
      if (!s_r.armed)
         seq_load = 1'b1;
      case (s_r.st)
         uhrs_pkg::DEV_RECOVER:
         begin
            if (s_r.armed && seq_done)
            begin
               s_nxt.oper = 1'b1;
               s_nxt.phy_en = 1'b1;
               s_nxt.mode = s_r.mode_s[3:2];
               if (s_r.mode_s[3:2] == uhrs_pkg::MODE_EEPROM)
               begin
                  s_nxt.st = uhrs_pkg::DEV_EE_LOAD;
                  s_nxt.cfg_start = 1'b1;
                  seq_load = 1'b1;
                  seq_val = TW'(EE_LOAD_CYC - EE_LAT);
               end
               else if (s_r.mode_s[3:2] == uhrs_pkg::MODE_SMBUS)
               begin
                  s_nxt.st = uhrs_pkg::DEV_SMB_LOAD;
               end
               else
               begin
                  s_nxt.st = uhrs_pkg::DEV_RUN;
                  s_nxt.attach = 1'b1;
               end
            end
         end
         uhrs_pkg::DEV_EE_LOAD:
         begin
            // Give up on a silent EEPROM and run on defaults
            if (s_r.done_s[1] || seq_done)
            begin
               s_nxt.st = uhrs_pkg::DEV_RUN;
               s_nxt.cfg_start = 1'b0;
               s_nxt.attach = 1'b1;
            end
         end
         uhrs_pkg::DEV_SMB_LOAD:
         begin
            // No deadline: stay detached until the load ends
            if (s_r.done_s[1])
            begin
               s_nxt.st = uhrs_pkg::DEV_RUN;
               s_nxt.attach = 1'b1;
            end
         end
         uhrs_pkg::DEV_RUN:
         begin
            s_nxt.led_en = 1'b1;
            s_nxt.port_en = port_en_req_i;
            s_nxt.port_pwr = port_pwr_req_i & {N{s_r.configured}};
            if (set_addr_i)
               s_nxt.addr = addr_i;
            if (set_cfg_i)
               s_nxt.configured = cfg_val_i;
            if (suspend_i)
               s_nxt.suspended = 1'b1;
            // Four-phase request handshake with a hard deadline
            if (s_r.req_s[2] && !s_r.req_pend && !s_r.req_done)
            begin
               s_nxt.req_pend = 1'b1;
               req_load = 1'b1;
            end
            else if (s_r.req_pend && (req_ack_i || req_tmo))
            begin
               s_nxt.req_pend = 1'b0;
               s_nxt.req_done = 1'b1;
               s_nxt.req_late = ~req_ack_i;
            end
            else if (s_r.req_done && !s_r.req_s[2])
            begin
               s_nxt.req_done = 1'b0;
            end
         end
         default:
         begin
            s_nxt.st = uhrs_pkg::DEV_RECOVER;
         end
      endcase
      // Upstream bus reset wins over software updates
      if (ubr)
      begin
         s_nxt.addr = uhrs_pkg::ADDR_DEFAULT;
         s_nxt.configured = 1'b0;
         s_nxt.port_pwr = '0;
         s_nxt.suspended = 1'b0;
      end
      // Port enables are left alone so no reset goes downstream
      if (ubr_rise)
         s_nxt.tt_clear = 1'b1;
   end

   // Everything returns to zero defaults while the pin is low
   always_ff @(posedge ref_clk_i or posedge core_rst)
   begin
      if (core_rst)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   // Link outputs
   assign link.cfg_start = s_r.cfg_start;
   assign link.attach = s_r.attach;
   assign link.req_done = s_r.req_done;

   // User side outputs
   assign port_enable_o = s_r.port_en;
   assign port_power_enable_o = s_r.port_pwr;
   assign phy_enable_o = s_r.phy_en;
   assign osc_enable_o = s_r.osc_en;
   assign pll_enable_o = s_r.pll_en;
   assign led_enable_o = s_r.led_en;
   assign operational_o = s_r.oper;
   assign mode_o = s_r.mode;
   assign addr_o = s_r.addr;
   assign configured_o = s_r.configured;
   assign suspended_o = s_r.suspended;
   assign tt_clear_o = s_r.tt_clear;
   assign req_o = s_r.req_pend;
   assign req_late_o = s_r.req_late;
endmodule

// ===== hdl/uhrs_host.sv
// Purpose: Upstream host and config source end of the reset sequence
// Assumes: Hub answers on the link asynchronously
// Notes: Strap mode follows mode_i, registered each cycle from reset onward
`timescale 1ns/1ps
module uhrs_host #(
   parameter int ATTACH_WAIT_CYC = uhrs_pkg::ATTACH_WAIT_CYC,
   parameter int BUS_RST_CYC = uhrs_pkg::BUS_RST_CYC
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Link to the hub
   uhrs_if.host link,
   // User controls
   input wire logic hw_reset_i,
   input wire logic [1:0] mode_i,
   input wire logic cfg_load_done_i,
   input wire logic req_i,
   // User status
   output logic attached_o,
   output logic ready_o,
   output logic cfg_start_o,
   output logic req_busy_o,
   output logic req_done_o
);
   localparam int TW = uhrs_pkg::TMR_W;

   typedef struct packed {
      uhrs_pkg::uhrs_host_state_type st;
      logic armed;
      logic reset_n;
      logic usb_reset;
      logic [1:0] mode;
      logic cfg_done;
      logic req;
      logic rdone;
      logic ready;
      logic [1:0] att_s;
      logic [1:0] done_s;
      logic [1:0] start_s;
   } uhrs_host_reg_type;

   uhrs_host_reg_type s_r;
   uhrs_host_reg_type s_nxt;
   logic tmr_load;
   logic [TW-1:0] tmr_val;
   logic tmr_done;

   // Shared phase timer
   uhrs_timer #(.W(TW)) u_tmr (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .load_i(tmr_load),
      .value_i(tmr_val),
      .done_o(tmr_done)
   );

   // Next state of the host sequence
   always_comb
   begin
      s_nxt = s_r;
      tmr_load = 1'b0;
      tmr_val = TW'(uhrs_pkg::HW_RST_CYC);
      s_nxt.armed = 1'b1;
      s_nxt.rdone = 1'b0;
      s_nxt.mode = mode_i;
      s_nxt.att_s = {s_r.att_s[0], link.attach};
      s_nxt.done_s = {s_r.done_s[0], link.req_done};
      s_nxt.start_s = {s_r.start_s[0], link.cfg_start};
      // Config source completion is registered and passed on, held low in H_RESET
      s_nxt.cfg_done = cfg_load_done_i;
      if (!s_r.armed)
         tmr_load = 1'b1;
      case (s_r.st)
         uhrs_pkg::H_RESET:
         begin
            s_nxt.cfg_done = 1'b0;
            if (s_r.armed && tmr_done)
            begin
               s_nxt.reset_n = 1'b1;
               s_nxt.st = uhrs_pkg::H_WAIT_ATT;
            end
         end
         uhrs_pkg::H_WAIT_ATT:
         begin
            if (s_r.att_s[1])
            begin
               s_nxt.st = uhrs_pkg::H_ATT_DLY;
               tmr_load = 1'b1;
               tmr_val = TW'(ATTACH_WAIT_CYC);
            end
         end
         uhrs_pkg::H_ATT_DLY:
         begin
            if (!s_r.att_s[1])
            begin
               s_nxt.st = uhrs_pkg::H_WAIT_ATT;
            end
            else if (tmr_done)
            begin
               s_nxt.st = uhrs_pkg::H_BUS_RST;
               s_nxt.usb_reset = 1'b1;
               tmr_load = 1'b1;
               tmr_val = TW'(BUS_RST_CYC);
            end
         end
         uhrs_pkg::H_BUS_RST:
         begin
            if (tmr_done)
            begin
               s_nxt.st = uhrs_pkg::H_READY;
               s_nxt.usb_reset = 1'b0;
               s_nxt.ready = 1'b1;
            end
         end
         uhrs_pkg::H_READY:
         begin
            if (!s_r.att_s[1])
            begin
               s_nxt.st = uhrs_pkg::H_WAIT_ATT;
               s_nxt.ready = 1'b0;
               s_nxt.req = 1'b0;
            end
            else if (req_i && !s_r.req && !s_r.done_s[1])
               s_nxt.req = 1'b1;
            else if (s_r.req && s_r.done_s[1])
            begin
               s_nxt.req = 1'b0;
               s_nxt.rdone = 1'b1;
            end
         end
         default:
         begin
            s_nxt.st = uhrs_pkg::H_RESET;
         end
      endcase
      // A new hardware reset restarts the whole sequence
      if (hw_reset_i)
      begin
         s_nxt = '0;
         s_nxt.armed = 1'b1;
         s_nxt.mode = mode_i;
         tmr_load = 1'b1;
         tmr_val = TW'(uhrs_pkg::HW_RST_CYC);
      end
   end

   // State register, reset pin low from reset onward
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   // Link outputs
   assign link.reset_n = s_r.reset_n;
   assign link.usb_reset = s_r.usb_reset;
   assign link.cfg_mode = s_r.mode;
   assign link.cfg_done = s_r.cfg_done;
   assign link.req = s_r.req;

   // User side outputs
   assign attached_o = s_r.att_s[1];
   assign ready_o = s_r.ready;
   assign cfg_start_o = s_r.start_s[1];
   assign req_busy_o = s_r.req;
   assign req_done_o = s_r.rdone;
endmodule

// ===== hdl/uhrs_if.sv
// Purpose: Link between the hub and its upstream host and config source
// Assumes: Each end synchronizes what it receives
// Notes: Request and completion form a four-phase level handshake
`timescale 1ns/1ps
interface uhrs_if;
   logic reset_n;
   logic usb_reset;
   logic [1:0] cfg_mode;
   logic cfg_start;
   logic cfg_done;
   logic attach;
   logic req;
   logic req_done;
   // Hub end
   modport dev (
      input reset_n, usb_reset, cfg_mode, cfg_done, req,
      output cfg_start, attach, req_done
   );
   // Upstream host and config source end
   modport host (
      output reset_n, usb_reset, cfg_mode, cfg_done, req,
      input cfg_start, attach, req_done
   );
endinterface

// ===== hdl/uhrs_pkg.sv
// Purpose: Shared constants and types for both ends of the hub reset sequencer
// Assumes: One 100 MHz reference clock on each end
// Notes: Times kept in their own unit, cycle counts derived from them
package uhrs_pkg;
   localparam int CLK_MHZ = 100;
   localparam int NUM_PORTS = 7;
   localparam int ADDR_W = 7;
   localparam int TMR_W = 24;
   localparam logic [1:0] MODE_STRAP = 2'h0;
   localparam logic [1:0] MODE_EEPROM = 2'h1;
   localparam logic [1:0] MODE_SMBUS = 2'h2;
   localparam logic [6:0] ADDR_DEFAULT = 7'h00;
   localparam int HW_RST_US = 1;
   localparam int HW_RST_CYC = HW_RST_US * CLK_MHZ;
   localparam int RECOVER_US = 500;
   localparam int RECOVER_CYC = RECOVER_US * CLK_MHZ;
   // 99.5 ms held in microseconds
   localparam int EE_LOAD_US = 99500;
   localparam int EE_LOAD_CYC = EE_LOAD_US * CLK_MHZ;
   localparam int REQ_MS = 5;
   localparam int REQ_CYC = REQ_MS * 1000 * CLK_MHZ;
   localparam int ATTACH_WAIT_MS = 100;
   localparam int ATTACH_WAIT_CYC = ATTACH_WAIT_MS * 1000 * CLK_MHZ;
   localparam int BUS_RST_MS = 10;
   localparam int BUS_RST_CYC = BUS_RST_MS * 1000 * CLK_MHZ;
   typedef enum logic [1:0] {DEV_RECOVER, DEV_EE_LOAD, DEV_SMB_LOAD, DEV_RUN} uhrs_dev_state_type;
   typedef enum logic [2:0] {
      H_RESET, H_WAIT_ATT, H_ATT_DLY, H_BUS_RST, H_READY
   } uhrs_host_state_type;
endpackage

// ===== hdl/uhrs_timer.sv
// Purpose: Loadable down counter that flags expiry
// Assumes: Load value is the wanted number of cycles
// Notes: Done stays high until the next load
`timescale 1ns/1ps
module uhrs_timer #(
   parameter int W = uhrs_pkg::TMR_W
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Control
   input wire logic load_i,
   input wire logic [W-1:0] value_i,
   // Status
   output logic done_o
);
   typedef struct packed {
      logic run;
      logic [W-1:0] cnt;
   } uhrs_tmr_type;

   uhrs_tmr_type s_r;
   uhrs_tmr_type s_nxt;

   // Load or count down to zero
   always_comb
   begin
      s_nxt = s_r;
      if (load_i)
      begin
         s_nxt.run = 1'b1;
         s_nxt.cnt = value_i;
      end
      else if (s_r.run && (s_r.cnt != '0))
      begin
         s_nxt.cnt = s_r.cnt - 1'b1;
      end
   end

   // State register
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   // Expiry flag
   assign done_o = s_r.run && (s_r.cnt == '0);
endmodule
